// ==== core/swwc_map.vh ====
// register offsets, field positions, reset values and timing counts
`ifndef SWWC_MAP_VH
`define SWWC_MAP_VH
// register word addresses
`define SWWC_ADDR_CTRL 4'h0
`define SWWC_ADDR_STATUS 4'h1
`define SWWC_ADDR_INTCTL 4'h2
`define SWWC_ADDR_IRQ 4'h3
// watchdog_control_reg fields
`define SWWC_WDC_SOFT_EN 0
`define SWWC_WDC_PS_LSB 1
`define SWWC_WDC_PS_MSB 5
`define SWWC_WDC_RESET 8'h16
// core_status fields
`define SWWC_ST_PD 3
`define SWWC_ST_TO 4
// interrupt_control fields
`define SWWC_IC_GIE 7
// watchdog modes
`define SWWC_WD_OFF 2'h0
`define SWWC_WD_SOFT 2'h1
`define SWWC_WD_NSLEEP 2'h2
`define SWWC_WD_ON 2'h3
// timing: lf oscillator ticks per 1 ms base interval, startup periods
`define SWWC_WD_BASE_TICKS 24'h20
`define SWWC_OST_PERIODS 11'h400
`endif

// ==== core/swwc_top.v ====
// sleep, wake and watchdog control with an avalon-mm register slave
//
// Behaviour
// - enter sleep only on the sleep instruction
// - clear watchdog on sleep entry, keep counting if enabled in sleep
// - sleep entry clears power-down flag and sets time-out flag
// - core clock gated off while asleep
// - low-frequency oscillator keeps running during sleep
// - timer, sensing oscillators and converter dedicated clock keep running
// - pins hold their pre-sleep state during sleep
// - sleep leaves non-watchdog reset sources unchanged
// - wake on pin, brownout, power-on, watchdog or enabled interrupts
// - pin, brownout, power-on wakes reset; watchdog and interrupts resume
// - sleep instruction prefetches instruction at pc plus one
// - interrupt wakes only if its enable set; global enable ignored
// - after wake, next instruction runs then vector if global enable and not a watchdog wake
// - watchdog cleared on every wake
// - sleep with pending enabled interrupt acts as no-op
// - interrupt during sleep: complete sleep, wake immediately, update flags
// - crystal modes wait 1024 oscillator periods before resuming
// - watchdog resets device when not cleared within period
// - watchdog counts low-frequency oscillator ticks
// - mode 11 watchdog always on
// - mode 10 watchdog on awake, off in sleep
// - mode 01 watchdog follows software enable bit
// - watchdog timeout in sleep wakes without reset, flags record it
// - reset period defaults to two seconds
// - watchdog held clear until startup timer ends after wake
`include "swwc_map.vh"
`default_nettype none
module swwc_top
(
   // clock and reset
   input wire mclk_in,
   input wire rst_n_in,
   // configuration and oscillator ticks
   input wire [1:0] watchdog_config_field_in,
   input wire crystal_mode_in,
   input wire lf_osc_tick_in,
   input wire osc_period_tick_in,
   // cpu core
   input wire sleep_instr_in,
   input wire watchdog_clear_instr_in,
   input wire [7:0] irq_flag_in,
   input wire [7:0] irq_enable_in,
   // reset-type wake sources, already reset the chip elsewhere
   input wire reset_wake_in,
   // pins
   input wire [7:0] pin_level_in,
   input wire [7:0] pin_oe_n_in,
   // avalon-mm slave
   input wire [3:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output reg avs_waitrequest,
   // outputs to the core and clock tree
   output reg core_clk_en_out,
   output reg asleep_out,
   output reg prefetch_next_out,
   output reg resume_out,
   output reg vector_call_out,
   output reg watchdog_reset_out,
   output reg lf_osc_run_out,
   output reg aux_osc_run_out,
   output reg [7:0] pin_level_out,
   output reg [7:0] pin_oe_n_out
);

////////////////////////////////////////////////////////////////////////////
// timing and state
localparam [23:0] WD_BASE = `SWWC_WD_BASE_TICKS;
localparam [10:0] OST_N = `SWWC_OST_PERIODS;
localparam [1:0] ST_RUN = 2'h0;
localparam [1:0] ST_SLEEP = 2'h1;
localparam [1:0] ST_OST = 2'h2;
localparam [1:0] ST_RESUME = 2'h3;

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [7:0] wdc_r;
reg pd_r;
reg to_r;
reg [7:0] intctl_r;
reg [23:0] wd_cnt_r;
reg [10:0] ost_cnt_r;
wire lf_tick_r;
wire ost_tick_r;
reg wd_wake_r;
reg bus_done_r;

wire [4:0] ps_code = wdc_r[`SWWC_WDC_PS_MSB:`SWWC_WDC_PS_LSB];
// codes above 18 are reserved; they fall back to the longest period
wire [4:0] ps_sel = (ps_code > 5'h12) ? 5'h12 : ps_code;
wire [23:0] wd_limit = WD_BASE << ps_sel;
wire in_sleep = (state_r == ST_SLEEP);

// enables gate wake, global enable is not consulted
wire irq_pending = |(irq_flag_in & irq_enable_in);

////////////////////////////////////////////////////////////////////////////
// watchdog mode decode
reg wd_active;
always @*
begin
   case (watchdog_config_field_in)
      `SWWC_WD_ON: wd_active = 1'b1;
      `SWWC_WD_NSLEEP: wd_active = !in_sleep;
      `SWWC_WD_SOFT: wd_active = wdc_r[`SWWC_WDC_SOFT_EN];
      default: wd_active = 1'b0;
   endcase
end

////////////////////////////////////////////////////////////////////////////
// pin-side tick synchronisers, three stages each
// a level counts once stages two and three agree; a tick is one cycle
// on a newly agreed high level, so a slow clock gives one tick per rising edge
wire [1:0] tick_raw = {osc_period_tick_in, lf_osc_tick_in};
wire [1:0] tick_pulse;
genvar gi;
generate
   for (gi = 0; gi < 2; gi = gi + 1)
   begin : g_tick
      reg [2:0] sync_r;
      reg level_r;
      reg pulse_r;
      always @(posedge mclk_in or negedge rst_n_in)
      begin
         if (!rst_n_in)
         begin
            sync_r <= 3'h0;
            level_r <= 1'b0;
            pulse_r <= 1'b0;
         end
         else
         begin
            sync_r <= {sync_r[1:0], tick_raw[gi]};
            // stages disagree: a change still settling, keep old level
            if (sync_r[1] == sync_r[2])
               level_r <= sync_r[2];
            pulse_r <= (sync_r[1] == sync_r[2]) && sync_r[2] && !level_r;
         end
      end
      assign tick_pulse[gi] = pulse_r;
   end
endgenerate

assign lf_tick_r = tick_pulse[0];
assign ost_tick_r = tick_pulse[1];

////////////////////////////////////////////////////////////////////////////
// sleep sequencer
wire sleep_go = (state_r == ST_RUN) && sleep_instr_in;
wire wd_expire = wd_active && lf_tick_r && (wd_cnt_r + 24'h1 >= wd_limit);

always @*
begin
   state_nxt = state_r;
   case (state_r)
      ST_RUN:
      begin
         // only the sleep instruction enters sleep
         // pending enabled interrupt makes it a no-op
         if (sleep_instr_in && !irq_pending)
            state_nxt = ST_SLEEP;
      end
      ST_SLEEP:
      begin
         // interrupt during sleep wakes at once
         if (irq_pending || wd_expire)
            state_nxt = crystal_mode_in ? ST_OST : ST_RESUME;
      end
      ST_OST:
      begin
         // wait startup periods in crystal modes only
         if (ost_tick_r && ost_cnt_r == OST_N - 11'h1)
            state_nxt = ST_RESUME;
      end
      ST_RESUME: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
   endcase
end

// reset-type wakes act through rst_n_in; here only resume
always @(posedge mclk_in or negedge rst_n_in)
begin
   if (!rst_n_in)
   begin
      state_r <= ST_RUN;
      ost_cnt_r <= 11'h0;
      wd_wake_r <= 1'b0;
   end
   else
   begin
      state_r <= state_nxt;
      if (state_r != ST_OST)
         ost_cnt_r <= 11'h0;
      else if (ost_tick_r)
         ost_cnt_r <= ost_cnt_r + 11'h1;
      if (in_sleep && wd_expire)
         wd_wake_r <= 1'b1;
      else if (state_r == ST_RUN)
         wd_wake_r <= 1'b0;
   end
end

////////////////////////////////////////////////////////////////////////////
// watchdog counter
// clear terms, one per cause
wire clr_entry = sleep_go && !irq_pending;
wire clr_instr = watchdog_clear_instr_in;
wire clr_off = !wd_active;
wire clr_wake = in_sleep && (state_nxt != ST_SLEEP);
wire clr_ost = (state_r == ST_OST);
wire wd_clear = clr_entry || clr_instr || clr_off || clr_wake || clr_ost;

always @(posedge mclk_in or negedge rst_n_in)
begin
   if (!rst_n_in)
   begin
      wd_cnt_r <= 24'h0;
      watchdog_reset_out <= 1'b0;
   end
   else
   begin
      // cleared on entry, counts on if active
      // held clear while startup timer runs
      if (wd_clear)
         wd_cnt_r <= 24'h0;
      else if (lf_tick_r)
         wd_cnt_r <= wd_expire ? 24'h0 : wd_cnt_r + 24'h1;
      // awake expiry resets; asleep expiry only wakes
      watchdog_reset_out <= wd_expire && !wd_clear && !in_sleep;
   end
end

////////////////////////////////////////////////////////////////////////////
// core-facing outputs
always @(posedge mclk_in or negedge rst_n_in)
begin
   if (!rst_n_in)
   begin
      core_clk_en_out <= 1'b1;
      asleep_out <= 1'b0;
      prefetch_next_out <= 1'b0;
      resume_out <= 1'b0;
      vector_call_out <= 1'b0;
      lf_osc_run_out <= 1'b1;
      aux_osc_run_out <= 1'b1;
      pin_level_out <= 8'h00;
      pin_oe_n_out <= 8'hff;
   end
   else
   begin
      core_clk_en_out <= (state_nxt == ST_RUN) || (state_nxt == ST_RESUME);
      asleep_out <= (state_nxt == ST_SLEEP);
      // fetch pc plus one while sleep executes
      prefetch_next_out <= sleep_go;
      // resume in line, vector flagged in the same cycle when global enable set and not a watchdog wake
      resume_out <= (state_r == ST_RESUME);
      vector_call_out <= (state_r == ST_RESUME) && !wd_wake_r &&
         intctl_r[`SWWC_IC_GIE];
      // low-frequency oscillator never stopped by sleep
      lf_osc_run_out <= 1'b1;
      // timer, sensing oscillators and converter clock stay on
      aux_osc_run_out <= 1'b1;
      // pins frozen at their pre-sleep state
      if (state_r == ST_RUN)
      begin
         pin_level_out <= pin_level_in;
         pin_oe_n_out <= pin_oe_n_in;
      end
   end
end

// no other reset source is gated by sleep; none pass through here

////////////////////////////////////////////////////////////////////////////
// read data selection; unmapped words read as zero
reg [31:0] rd_mux;
always @*
begin
   rd_mux = 32'h0;
   case (avs_address)
      `SWWC_ADDR_CTRL:
         rd_mux = {24'h0, 2'h0, wdc_r[5:0]};
      `SWWC_ADDR_STATUS:
         rd_mux = {24'h0, 3'h0, to_r, pd_r, 2'h0, wd_wake_r};
      `SWWC_ADDR_INTCTL:
         rd_mux = {24'h0, intctl_r};
      `SWWC_ADDR_IRQ:
         rd_mux = {16'h0, irq_enable_in, irq_flag_in};
      default:
         rd_mux = 32'h0;
   endcase
end

////////////////////////////////////////////////////////////////////////////
// registers and avalon-mm slave, one wait cycle per access
wire bus_req = (avs_read || avs_write) && !bus_done_r;
// write lands at the edge where the master sees waitrequest low
wire wr_hit = avs_write && bus_done_r;

always @(posedge mclk_in or negedge rst_n_in)
begin
   if (!rst_n_in)
   begin
      wdc_r <= `SWWC_WDC_RESET;
      intctl_r <= 8'h00;
      bus_done_r <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
   end
   else
   begin
      bus_done_r <= bus_req;
      avs_waitrequest <= !bus_req;
      if (bus_req)
         avs_readdata <= rd_mux;
      // only the low byte holds storage; other lanes are ignored
      if (wr_hit && avs_byteenable[0])
      begin
         if (avs_address == `SWWC_ADDR_CTRL)
            wdc_r <= {2'h0, avs_writedata[5:0]};
         if (avs_address == `SWWC_ADDR_INTCTL)
            intctl_r <= avs_writedata[7:0];
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// status flags; sleep entry wins over a clear in the same cycle
always @(posedge mclk_in or negedge rst_n_in)
begin
   if (!rst_n_in)
   begin
      pd_r <= 1'b1;
      to_r <= 1'b1;
   end
   else
   begin
      // sleep entry clears power-down, sets time-out
      // also on interrupt-cut sleep, which still completes
      if (state_r == ST_RUN && state_nxt == ST_SLEEP)
      begin
         pd_r <= 1'b0;
         to_r <= 1'b1;
      end
      else if (in_sleep && wd_expire)
         to_r <= 1'b0;
      // watchdog clear sets both flags
      else if (watchdog_clear_instr_in && state_r == ST_RUN)
      begin
         pd_r <= 1'b1;
         to_r <= 1'b1;
      end
   end
end

endmodule
`default_nettype wire

// ==== dv/swwc_monitor.sv ====
// concurrent checks on the sleep and watchdog block ports
`default_nettype none
module swwc_monitor
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // inputs watched
   input wire logic crystal_mode_in,
   input wire logic sleep_instr_in,
   input wire logic [7:0] irq_flag_in,
   input wire logic [7:0] irq_enable_in,
   // outputs watched
   input wire logic core_clk_en_out,
   input wire logic asleep_out,
   input wire logic prefetch_next_out,
   input wire logic resume_out,
   input wire logic vector_call_out,
   input wire logic watchdog_reset_out,
   input wire logic lf_osc_run_out,
   input wire logic aux_osc_run_out,
   input wire logic [7:0] pin_level_out,
   input wire logic [7:0] pin_oe_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic pend;
   assign pend = |(irq_flag_in & irq_enable_in);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   sleep_entry_a:
      assert property (sleep_instr_in && core_clk_en_out && !asleep_out
         && !pend |=> asleep_out && prefetch_next_out) else $error("entry");
   sleep_noop_a:
      assert property (sleep_instr_in && core_clk_en_out && pend
         |=> !asleep_out) else $error("noop");
   clk_gate_a:
      assert property (asleep_out |-> !core_clk_en_out) else $error("gate");
   osc_run_a:
      assert property (lf_osc_run_out && aux_osc_run_out) else $error("osc");
   pin_hold_a:
      assert property (asleep_out [*2] |-> $stable(pin_level_out)
         && $stable(pin_oe_n_out)) else $error("pins");
   irq_wake_a:
      assert property (asleep_out && pend && !crystal_mode_in
         |-> ##[1:6] resume_out) else $error("wake");
   vector_a:
      assert property (vector_call_out |-> resume_out) else $error("vec");
   sleep_no_reset_a:
      assert property (asleep_out |-> !watchdog_reset_out) else $error("rst");
endmodule
bind swwc_top swwc_monitor mon (.mclk_in, .rst_n_in, .crystal_mode_in,
   .sleep_instr_in, .irq_flag_in, .irq_enable_in, .core_clk_en_out,
   .asleep_out, .prefetch_next_out, .resume_out, .vector_call_out,
   .watchdog_reset_out, .lf_osc_run_out, .aux_osc_run_out, .pin_level_out,
   .pin_oe_n_out);
`default_nettype wire

// ==== dv/swwc_core_model.sv ====
// behavioural cpu core issuing sleep and watchdog-clear strobes
`default_nettype none
module swwc_core_model
(
   // clock
   input wire logic mclk_in,
   // instruction strobes
   output logic sleep_instr_out,
   output logic clear_instr_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      sleep_instr_out = 1'b0;
      clear_instr_out = 1'b0;
   end
   task automatic issue(input logic clr);
      @(posedge mclk_in);
      sleep_instr_out <= !clr;
      clear_instr_out <= clr;
      @(posedge mclk_in);
      {sleep_instr_out, clear_instr_out} <= 2'h0;
   endtask
endmodule
`default_nettype wire

// ==== dv/swwc_tb_top.sv ====
// self-checking bench for the sleep, wake and watchdog block
`include "swwc_map.vh"
`default_nettype none
module sleep_wake_watchdog_control_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in, rst_n_in, crystal_mode_in, lf_osc_tick_in;
   logic osc_period_tick_in, sleep_instr_in, watchdog_clear_instr_in;
   logic avs_read, avs_write, avs_waitrequest, core_clk_en_out, asleep_out;
   logic prefetch_next_out, resume_out, vector_call_out, watchdog_reset_out;
   logic lf_osc_run_out, aux_osc_run_out;
   logic reset_wake_in, be_lo;
   logic [3:0] avs_byteenable;
   logic [1:0] watchdog_config_field_in;
   logic [2:0] lf_div;
   logic [3:0] avs_address;
   logic [7:0] irq_flag_in, irq_enable_in, pin_level_in, pin_oe_n_in;
   logic [7:0] pin_level_out, pin_oe_n_out;
   logic [31:0] avs_writedata, avs_readdata;
   logic [63:0] note;
   logic [63:0] notes[$];
   int compares, miscompares;
   swwc_top dut
   (
      .mclk_in, .rst_n_in, .watchdog_config_field_in, .crystal_mode_in,
      .lf_osc_tick_in, .osc_period_tick_in, .sleep_instr_in,
      .watchdog_clear_instr_in, .irq_flag_in, .irq_enable_in,
      .reset_wake_in, .pin_level_in, .pin_oe_n_in, .avs_address,
      .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .core_clk_en_out, .asleep_out,
      .prefetch_next_out, .resume_out, .vector_call_out, .watchdog_reset_out,
      .lf_osc_run_out, .aux_osc_run_out, .pin_level_out, .pin_oe_n_out
   );
   swwc_core_model core
   (
      .mclk_in,
      .sleep_instr_out(sleep_instr_in),
      .clear_instr_out(watchdog_clear_instr_in)
   );
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk_in = 1'b0;
      forever #5 mclk_in = ~mclk_in;
   end
   // wandering pins make any leak through the sleep freeze visible
   always @(posedge mclk_in)
   begin
      lf_div <= lf_div + 3'h1;
      lf_osc_tick_in <= lf_div[2];
      // slow enough that two synchroniser stages can agree
      osc_period_tick_in <= lf_div[1];
      pin_level_in <= 8'($urandom);
      pin_oe_n_in <= 8'($urandom);
   end
   always @(posedge mclk_in)
      if (avs_read && !avs_waitrequest)
      begin
         note = notes.pop_front();
         chk(avs_readdata & note[63:32], note[31:0]);
      end
   ////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         miscompares++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask
   // reads leave their expectation queued for the watcher
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, input logic [31:0] m);
      int i;
      if (!w)
         notes.push_back({m, d & m});
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= {3'($urandom), be_lo};
      avs_read <= !w;
      avs_write <= w;
      i = 0;
      do
      begin
         @(posedge mclk_in);
         i++;
      end while (avs_waitrequest && i < 20);
      if (avs_waitrequest)
      begin
         miscompares++;
         final_report();
      end
      {avs_read, avs_write} <= 2'h0;
      @(posedge mclk_in);
   endtask
   task automatic see(ref logic s, input int lim, input logic exp);
      int i;
      logic hit;
      hit = 1'b0;
      for (i = 0; i < lim && !hit; i++)
      begin
         @(posedge mclk_in);
         hit = s;
      end
      chk(32'(hit), 32'(exp));
      if (exp && !hit)
         final_report();
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      void'($urandom(57));
      {rst_n_in, crystal_mode_in, lf_osc_tick_in, osc_period_tick_in} = 4'h0;
      {avs_read, avs_write, lf_div, avs_address, avs_writedata} = '0;
      {reset_wake_in, be_lo, avs_byteenable} = 6'h1f;
      {irq_flag_in, irq_enable_in, pin_level_in, pin_oe_n_in} = '0;
      watchdog_config_field_in = `SWWC_WD_OFF;
      repeat (4) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      bus(1'b0, `SWWC_ADDR_CTRL, `SWWC_WDC_RESET, 32'hff);
      bus(1'b0, 4'h9, 32'h0, 32'hffffffff);
      bus(1'b1, `SWWC_ADDR_INTCTL, 32'h80, 32'h0);
      bus(1'b1, `SWWC_ADDR_CTRL, 32'h01, 32'h0);
      irq_flag_in <= 8'($urandom) | 8'h01;
      core.issue(1'b0);
      bus(1'b0, `SWWC_ADDR_STATUS, 32'h10, 32'h18);
      see(resume_out, 300, 1'b0);
      irq_enable_in <= 8'h01;
      see(resume_out, 8, 1'b1);
      chk(32'(vector_call_out), 32'h1);
      {irq_flag_in, irq_enable_in} <= 16'h0202;
      core.issue(1'b1);
      bus(1'b0, `SWWC_ADDR_STATUS, 32'h18, 32'h18);
      core.issue(1'b0);
      see(asleep_out, 6, 1'b0);
      bus(1'b0, `SWWC_ADDR_STATUS, 32'h18, 32'h18);
      {irq_flag_in, irq_enable_in} <= 16'h0;
      bus(1'b1, `SWWC_ADDR_INTCTL, 32'h0, 32'h0);
      watchdog_config_field_in <= `SWWC_WD_ON;
      repeat (3)
      begin
         see(watchdog_reset_out, 150, 1'b0);
         core.issue(1'b1);
      end
      see(watchdog_reset_out, 600, 1'b1);
      core.issue(1'b0);
      see(resume_out, 700, 1'b1);
      chk(32'(vector_call_out), 32'h0);
      watchdog_config_field_in <= `SWWC_WD_NSLEEP;
      core.issue(1'b0);
      see(resume_out, 700, 1'b0);
      {irq_flag_in, irq_enable_in} <= 16'h8080;
      see(resume_out, 8, 1'b1);
      {irq_flag_in, irq_enable_in} <= 16'h0;
      watchdog_config_field_in <= `SWWC_WD_SOFT;
      see(watchdog_reset_out, 600, 1'b1);
      bus(1'b1, `SWWC_ADDR_CTRL, 32'h0, 32'h0);
      see(watchdog_reset_out, 600, 1'b0);
      // mid-run reset: defaults return, a lane-masked write is ignored
      rst_n_in <= 1'b0;
      reset_wake_in <= 1'b1;
      repeat (2) @(posedge mclk_in);
      {rst_n_in, reset_wake_in} <= 2'h2;
      @(posedge mclk_in);
      bus(1'b0, `SWWC_ADDR_STATUS, 32'h18, 32'h19);
      be_lo = 1'b0;
      bus(1'b1, `SWWC_ADDR_CTRL, 32'h0, 32'h0);
      be_lo = 1'b1;
      bus(1'b0, `SWWC_ADDR_CTRL, `SWWC_WDC_RESET, 32'hff);
      crystal_mode_in <= 1'b1;
      core.issue(1'b0);
      {irq_flag_in, irq_enable_in} <= 16'h1010;
      see(resume_out, 3500, 1'b0);
      see(resume_out, 1500, 1'b1);
      final_report();
   end
endmodule
`default_nettype wire
